// File: logic/arf_pkg.sv
// Constants shared by the result formatter and its readout logic.
// Assumes one 25 MHz clock and an active-high asynchronous reset.
package arf_pkg;

	// ==========================================
	// Register map
	localparam logic [3:0] ADDR_RESULT = 4'h0;

	// ==========================================
	// Output format codes
	localparam logic [1:0] FMT_CODE16     = 2'h0;
	localparam logic [1:0] FMT_CODE16_PAD = 2'h1;
	localparam logic [1:0] FMT_CODE17     = 2'h2;
	localparam logic [1:0] FMT_CODE17_TAG = 2'h3;
	localparam int         FMT_WIDE_BIT   = 1;

	// ==========================================
	// Code widths and limits
	localparam int          CODE16_W   = 16;
	localparam int          CODE17_W   = 17;
	localparam int          TAG_W      = 4;
	localparam int          WORD_W     = 32;
	localparam logic [5:0]  LEN_SHORT  = 6'h10;
	localparam logic [5:0]  LEN_LONG   = 6'h20;
	localparam logic [15:0] CODE16_MAX = 16'h7FFF;
	localparam logic [15:0] CODE16_MIN = 16'h8000;
	localparam logic [16:0] CODE17_MAX = 17'h0FFFF;
	localparam logic [16:0] CODE17_MIN = 17'h10000;
	localparam logic [16:0] RESULT_RST = 17'h00000;
	localparam logic [3:0]  TAG_MUX    = 4'h0;
	localparam logic [15:0] PAD_ZERO   = 16'h0000;

	// ==========================================
	// Supply detection time
	localparam int CLK_NS         = 40;
	localparam int POR_DETECT_NS  = 1000;
	localparam int POR_DETECT_CYC = (POR_DETECT_NS + CLK_NS - 1) / CLK_NS;

endpackage

// File: logic/arf_result_if.sv
// Carries the stored code to the layout stage and the laid-out word back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface arf_result_if;
	logic [16:0] code17;
	logic [1:0]  format;
	logic [3:0]  tag;
	logic [31:0] word;
	logic [5:0]  length;

	modport source (output code17, output format, output tag, input word, input length);
	modport shaper (input code17, input format, input tag, output word, output length);
endinterface
`default_nettype wire

// File: logic/arf_layout.sv
// Turns the stored 17-bit code into one of four readout layouts.
// Assumes the code is already rounded and clamped to 17 bits.
`timescale 1ns/1ps
`default_nettype none
module arf_layout (
	// Code in, word out
	arf_result_if.shaper res
);
	logic [15:0] code16;
	logic        signBit;

	// ==========================================
	// Sixteen-bit clamp of the 17-bit code
	always_comb begin
		signBit = res.code17[16];
		if (res.code17[16] != res.code17[15]) begin
			code16 = signBit ? arf_pkg::CODE16_MIN : arf_pkg::CODE16_MAX;
		end else begin
			code16 = res.code17[15:0];
		end
	end

	// ==========================================
	// Layout select
	always_comb begin
		unique case (res.format)
			arf_pkg::FMT_CODE16: begin
				res.word   = {code16, arf_pkg::PAD_ZERO};
				res.length = arf_pkg::LEN_SHORT;
			end
			arf_pkg::FMT_CODE16_PAD: begin
				res.word   = {code16, arf_pkg::PAD_ZERO};
				res.length = arf_pkg::LEN_LONG;
			end
			arf_pkg::FMT_CODE17: begin
				res.word   = {{15{signBit}}, res.code17};
				res.length = arf_pkg::LEN_LONG;
			end
			arf_pkg::FMT_CODE17_TAG: begin
				res.word   = {res.tag, {11{signBit}}, res.code17};
				res.length = arf_pkg::LEN_LONG;
			end
		endcase
	end
endmodule
`default_nettype wire

// File: logic/arf_result_formatter.sv
// Conversion result register with rounding, clamping, layout and
// power-on-reset handling behind a chip-select framed serial readout.
// Assumes pins are synchronous to clk and the filter pulses convDone.
`timescale 1ns/1ps
`default_nettype none
module arf_result_formatter #(
	parameter int FILT_W     = 24,
	parameter int ROUND_BITS = 6
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// Supply monitors
	input  wire logic              analogSupplyGood,
	input  wire logic              digitalSupplyGood,
	input  wire logic              fullShutdown,
	input  wire logic              supplyCollapse,
	// Decimation filter
	input  wire logic [FILT_W-1:0] filterResult,
	input  wire logic              convDone,
	input  wire logic              fullResetCmd,
	// Setup and scan state
	input  wire logic [1:0]        dataFormat,
	input  wire logic              scanActive,
	input  wire logic [3:0]        scanChannel,
	input  wire logic [7:0]        inputPairSelect,
	// Serial pins
	input  wire logic              csN,
	input  wire logic              sck,
	output logic                   sdoOut,
	output logic                   sdoOe,
	output logic                   irqN,
	// Status
	output logic                   porActive,
	output logic [16:0]            resultCode
);

	localparam int RND_W = FILT_W + 1;

	typedef enum logic [2:0] {
		ARF_POR  = 3'b001,
		ARF_IDLE = 3'b010,
		ARF_SEND = 3'b100
	} arf_state_e;

	arf_state_e  state_reg;
	arf_state_e  state_next;
	logic        csPrev_reg;
	logic        sckPrev_reg;
	logic        csArmed_reg;
	logic [15:0] goodCnt_reg;
	logic [16:0] result_reg;
	logic [31:0] shift_reg;
	logic [5:0]  bitsLeft_reg;
	logic        sdo_reg;
	logic        sdoOe_reg;
	logic        irqN_reg;
	logic        porActive_reg;

	logic              supplyBad;
	logic              supplyStable;
	logic              csFall;
	logic              csRise;
	logic              sckRise;
	logic              startRead;
	logic signed [RND_W-1:0] extended;
	logic signed [RND_W-1:0] summed;
	logic signed [RND_W-1:0] rounded;
	logic              fits17;
	logic [16:0]       clamped;

	arf_result_if res ();

	// ==========================================
	// Layout stage
	// Layout applied at readout, so a format change needs no new conversion
	arf_layout layout (
		.res (res.shaper)
	);

	assign res.code17 = result_reg;
	assign res.format = dataFormat;
	// Tag reads zero outside scanning, whatever input pair is selected
	assign res.tag    = scanActive ? scanChannel : arf_pkg::TAG_MUX;

	// ==========================================
	// Supply supervision
	always_comb begin
		if (fullShutdown) begin
			// Monitors asleep; only a collapsing supply still resets
			supplyBad = supplyCollapse;
		end else begin
			supplyBad = !(analogSupplyGood && digitalSupplyGood);
		end
	end

	assign supplyStable = (goodCnt_reg >= 16'(arf_pkg::POR_DETECT_CYC - 1));

	// Supplies must stay good for the whole detection time; any dip restarts it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			goodCnt_reg <= 16'h0000;
		end else if (supplyBad) begin
			goodCnt_reg <= 16'h0000;
		end else if (!supplyStable) begin
			goodCnt_reg <= goodCnt_reg + 16'h0001;
		end
	end

	// Bad supply wins over release in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			porActive_reg <= 1'b1;
		end else if (supplyBad) begin
			porActive_reg <= 1'b1;
		end else if (supplyStable) begin
			porActive_reg <= 1'b0;
		end
	end

	// ==========================================
	// Pin edge detection
	// Pins are synchronous to clk, so one flop per pin is enough
	// Idle levels as reset values, so no false edge follows reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			csPrev_reg <= 1'b1;
		end else begin
			csPrev_reg <= csN;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sckPrev_reg <= 1'b0;
		end else begin
			sckPrev_reg <= sck;
		end
	end

	assign csFall  = csPrev_reg && !csN;
	assign csRise  = !csPrev_reg && csN;
	assign sckRise = !sckPrev_reg && sck;

	// Chip select must be seen high after reset before a frame counts
	// A host holding chip select low through reset must raise it first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			csArmed_reg <= 1'b0;
		end else if (porActive_reg) begin
			csArmed_reg <= 1'b0;
		end else if (csN) begin
			csArmed_reg <= 1'b1;
		end
	end

	assign startRead = csFall && csArmed_reg && !porActive_reg;

	// ==========================================
	// Rounding and 17-bit clamp
	// One extra sign bit keeps the rounding sum from overflowing
	// Half an LSb added before the arithmetic shift: ties round upward
	always_comb begin
		extended = {filterResult[FILT_W-1], filterResult};
		summed   = extended + (RND_W'(1) <<< (ROUND_BITS - 1));
		rounded  = summed >>> ROUND_BITS;
		fits17   = (&rounded[RND_W-1:16]) || !(|rounded[RND_W-1:16]);
		// Beyond 17 bits the code locks at its limit; the two 16-bit layouts clamp again to 16
		if (fits17) begin
			clamped = rounded[16:0];
		end else if (rounded[RND_W-1]) begin
			clamped = arf_pkg::CODE17_MIN;
		end else begin
			clamped = arf_pkg::CODE17_MAX;
		end
	end

	// ==========================================
	// Conversion result register
	// Clear and power-on reset win over a capture in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_reg <= arf_pkg::RESULT_RST;
		end else if (porActive_reg || fullResetCmd) begin
			result_reg <= arf_pkg::RESULT_RST;
		end else if (convDone) begin
			result_reg <= clamped;
		end
	end

	// ==========================================
	// Readout state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ARF_POR: begin
				if (!porActive_reg) begin
					state_next = ARF_IDLE;
				end
			end
			ARF_IDLE: begin
				if (startRead) begin
					state_next = ARF_SEND;
				end
			end
			ARF_SEND: begin
				// Frame ends on the rise wherever the bit count stands
				if (csRise) begin
					state_next = ARF_IDLE;
				end
			end
		endcase
		// Power-on reset overrides every transition above
		if (porActive_reg) begin
			state_next = ARF_POR;
		end
	end

	// One-hot state; reset lands in the power-on state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ARF_POR;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Shift register, MSB first
	// Word latched at frame start, so a format change mid-frame waits a frame
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_reg <= 32'h00000000;
		end else if (porActive_reg || csRise) begin
			shift_reg <= 32'h00000000;
		end else if (state_reg == ARF_IDLE && startRead) begin
			shift_reg <= res.word;
		end else if (state_reg == ARF_SEND && sckRise && bitsLeft_reg != 6'h00) begin
			shift_reg <= {shift_reg[30:0], 1'b0};
		end
	end

	// ==========================================
	// Bits still owed in this frame; zeros follow once it runs out
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bitsLeft_reg <= 6'h00;
		end else if (porActive_reg || csRise) begin
			bitsLeft_reg <= 6'h00;
		end else if (state_reg == ARF_IDLE && startRead) begin
			bitsLeft_reg <= res.length;
		end else if (state_reg == ARF_SEND && sckRise && bitsLeft_reg != 6'h00) begin
			bitsLeft_reg <= bitsLeft_reg - 6'h01;
		end
	end

	// ==========================================
	// Serial output pin
	// First bit comes straight from the laid-out word, one cycle after the fall
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sdo_reg <= 1'b0;
		end else if (state_next != ARF_SEND) begin
			sdo_reg <= 1'b0;
		end else if (state_reg == ARF_IDLE) begin
			sdo_reg <= res.word[31];
		end else begin
			sdo_reg <= shift_reg[31];
		end
	end

	// Driver off whenever no frame runs, and from the clock after power-on reset starts
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sdoOe_reg <= 1'b0;
		end else begin
			sdoOe_reg <= (state_next == ARF_SEND) && !porActive_reg;
		end
	end

	// ==========================================
	// Reset interrupt, active low
	// Power-on reset sets the flag and wins over a clear in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqN_reg <= 1'b0;
		end else if (porActive_reg) begin
			irqN_reg <= 1'b0;
		end else if (startRead) begin
			irqN_reg <= 1'b1;
		end
	end

	// ==========================================
	// Outputs
	// Every output comes straight from a flip-flop
	assign sdoOut     = sdo_reg;
	assign sdoOe      = sdoOe_reg;
	assign irqN       = irqN_reg;
	assign porActive  = porActive_reg;
	assign resultCode = result_reg;

endmodule
`default_nettype wire

// File: sim/arf_result_formatter_chk.sv
// Port-level checks on the result formatter, bound to every instance.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module arf_result_formatter_chk #(
	parameter int FILT_W     = 24,
	parameter int ROUND_BITS = 6
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              reset,
	// Supplies
	input wire logic              analogSupplyGood,
	input wire logic              digitalSupplyGood,
	input wire logic              fullShutdown,
	input wire logic              supplyCollapse,
	// Filter
	input wire logic [FILT_W-1:0] filterResult,
	input wire logic              convDone,
	input wire logic              fullResetCmd,
	// Serial and status
	input wire logic              csN,
	input wire logic              sdoOe,
	input wire logic              irqN,
	input wire logic              porActive,
	input wire logic [16:0]       resultCode
);
	logic goodBoth;
	int   goodRun;
	assign goodBoth = analogSupplyGood && digitalSupplyGood;
	// ==========================================
	// Run of consecutive good-supply edges
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			goodRun <= 0;
		end else if (!goodBoth) begin
			goodRun <= 0;
		end else begin
			goodRun <= goodRun + 1;
		end
	end
	function automatic logic [16:0] codeOf(input logic [FILT_W-1:0] f);
		longint r;
		r = ($signed(f) + (longint'(1) <<< (ROUND_BITS - 1))) >>> ROUND_BITS;
		r = (r > 65535) ? 65535 : ((r < -65536) ? -65536 : r);
		return 17'(r);
	endfunction
	// ==========================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence sCsRise;
		!csN ##1 csN;
	endsequence
	a_por_quiet: assert property (porActive && $past(porActive)
		|-> resultCode == 17'h00000 && !sdoOe && !irqN) else $error("Output active in reset");
	a_bad_supply: assert property (!fullShutdown && !goodBoth |=> porActive)
		else $error("Bad supply without reset state");
	a_shutdown_hold: assert property (fullShutdown && !supplyCollapse && !porActive
		&& goodRun == 0 |=> !porActive) else $error("Reset state entered in shutdown");
	a_collapse_por: assert property (fullShutdown && supplyCollapse |=> porActive)
		else $error("Collapse without reset state");
	a_leave_por: assert property ($fell(porActive) |-> goodRun >= arf_pkg::POR_DETECT_CYC)
		else $error("Reset left too early");
	a_capture_code: assert property (convDone && !porActive && !fullResetCmd && goodBoth
		|=> resultCode == codeOf($past(filterResult))) else $error("Wrong stored code");
	a_hold_result: assert property (!convDone && !fullResetCmd && goodBoth && !porActive
		&& !fullShutdown |=> $stable(resultCode)) else $error("Result changed unasked");
	a_clear_cmd: assert property (fullResetCmd |=> resultCode == 17'h00000)
		else $error("Result not cleared");
	a_frame_start: assert property ($rose(sdoOe) |-> $past(csN, 2) && !$past(csN) && irqN)
		else $error("Frame start wrong");
	a_cs_release: assert property (sCsRise |=> !sdoOe)
		else $error("Output held after chip select rise");
endmodule
bind arf_result_formatter arf_result_formatter_chk #(.FILT_W(FILT_W), .ROUND_BITS(ROUND_BITS))
	chk_inst (.clk, .reset, .analogSupplyGood, .digitalSupplyGood, .fullShutdown,
	.supplyCollapse, .filterResult, .convDone, .fullResetCmd, .csN, .sdoOe, .irqN, .porActive,
	.resultCode);
`default_nettype wire

// File: sim/arf_host_model.sv
// Host model: one chip-select framed read of 32 bits, MSB first.
// Assumes the device samples sck on clk and registers sdoOut.
`timescale 1ns/1ps
`default_nettype none
module arf_host_model (
	// Clock
	input  wire logic  clk,
	// Device side
	input  wire logic  sdoOut,
	output logic       csN = 1'b1,
	output logic       sck = 1'b0,
	// Bench side
	input  wire logic  start,
	output logic [31:0] word = 32'h00000000,
	output logic       done = 1'b0
);
	always @(posedge clk) begin
		if (start) begin
			// Chip select high before every fall
			repeat (2) @(posedge clk);
			csN <= 1'b0;
			repeat (3) @(posedge clk);
			for (int i = 31; i >= 0; i--) begin
				word[i] <= sdoOut;
				sck <= 1'b1;
				repeat (2) @(posedge clk);
				sck <= 1'b0;
				repeat (2) @(posedge clk);
			end
			csN <= 1'b1;
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the result formatter and its serial readout.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        aGood = 1'b1;
	logic        dGood = 1'b1;
	logic        shut = 1'b0;
	logic        collapse = 1'b0;
	logic [23:0] filt = 24'h000000;
	logic        convDone = 1'b0;
	logic        clr = 1'b0;
	logic [1:0]  fmt = 2'h0;
	logic        scan = 1'b0;
	logic [3:0]  chan = 4'h0;
	logic [7:0]  pair = 8'h00;
	logic        start = 1'b0;
	logic [16:0] cur = 17'h00000;
	logic [31:0] expQ [$];
	int          miscompares = 0;
	int          checksDone = 0;
	wire logic   csN, sck, sdoOut, sdoOe, irqN, porActive, done;
	wire logic [16:0] resultCode;
	wire logic [31:0] word;
	always #20 clk = ~clk;
	arf_result_formatter arf_result_formatter_inst (.clk(clk), .reset(reset),
		.analogSupplyGood(aGood), .digitalSupplyGood(dGood), .fullShutdown(shut),
		.supplyCollapse(collapse), .filterResult(filt), .convDone(convDone),
		.fullResetCmd(clr), .dataFormat(fmt), .scanActive(scan), .scanChannel(chan),
		.inputPairSelect(pair), .csN(csN), .sck(sck), .sdoOut(sdoOut), .sdoOe(sdoOe),
		.irqN(irqN), .porActive(porActive), .resultCode(resultCode));
	arf_host_model arf_host_model_inst (.clk(clk), .sdoOut(sdoOut), .csN(csN), .sck(sck),
		.start(start), .word(word), .done(done));
	function automatic logic [16:0] code17(input logic [23:0] f);
		int r;
		r = ($signed(f) + 32) >>> 6;
		r = (r > 65535) ? 65535 : ((r < -65536) ? -65536 : r);
		return 17'(r);
	endfunction
	function automatic logic [31:0] wordOf(input logic [16:0] c, input logic [1:0] f,
		input logic [3:0] t);
		logic [15:0] c16;
		c16 = (c[16] == c[15]) ? c[15:0] : (c[16] ? 16'h8000 : 16'h7FFF);
		case (f)
			2'h0, 2'h1: return {c16, 16'h0000};
			2'h2: return {{15{c[16]}}, c};
			default: return {t, {11{c[16]}}, c};
		endcase
	endfunction
	task automatic fail(input string m);
		miscompares++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic cmpWord(input logic [31:0] g, input logic [31:0] e);
		checksDone++;
		if (g !== e) fail($sformatf("word %h, expected %h", g, e));
	endtask
	task automatic cmpCode(input logic [16:0] g, input logic [16:0] e);
		checksDone++;
		if (g !== e) fail($sformatf("code %h, expected %h", g, e));
	endtask
	task automatic cmpFlag(input logic g, input logic e);
		checksDone++;
		if (g !== e) fail("flag mismatch");
	endtask
	task automatic testDone();
		if (expQ.size() != 0) fail("frames never seen");
		$display("Checks %0d, miscompares %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic waitFor(input logic v, input bit onDone);
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			if ((onDone ? done : porActive) === v) return;
		end
		fail("wait timed out");
		testDone();
	endtask
	task automatic conv(input logic [23:0] f);
		@(posedge clk);
		filt <= f;
		convDone <= 1'b1;
		scan <= 1'($urandom);
		chan <= 4'($urandom);
		pair <= 8'($urandom);
		@(posedge clk);
		convDone <= 1'b0;
		@(posedge clk);
		cur = code17(f);
		#1 cmpCode(resultCode, cur);
	endtask
	task automatic readWord(input logic [1:0] f);
		@(posedge clk);
		fmt <= f;
		expQ.push_back(wordOf(cur, f, scan ? chan : 4'h0));
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		waitFor(1'b1, 1'b1);
	endtask
	// ==========================================
	// Result monitor
	always @(posedge clk) begin
		if (done === 1'b1) begin
			if (expQ.size() == 0) fail("unexpected frame");
			else cmpWord(word, expQ.pop_front());
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [23:0] tv [8];
		tv = '{24'h000020, 24'h00001F, 24'h7FFFFF, 24'h800000, 24'hFFFFE0, 24'h200000,
			24'hDFFFC0, 24'h0001FF};
		void'($urandom(28646));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		waitFor(1'b0, 1'b0);
		#1 cmpFlag(irqN, 1'b0);
		readWord(2'h0);
		#1 cmpFlag(irqN, 1'b1);
		for (int i = 0; i < 14; i++) begin
			conv((i < 8) ? tv[i] : 24'($urandom));
			readWord(2'(i));
		end
		readWord(2'h3);
		readWord(2'h1);
		@(posedge clk);
		clr <= 1'b1;
		convDone <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		convDone <= 1'b0;
		@(posedge clk);
		#1 cmpCode(resultCode, 17'h00000);
		conv(24'h000400);
		aGood <= 1'b0;
		waitFor(1'b1, 1'b0);
		dGood <= 1'b0;
		aGood <= 1'b1;
		#1 cmpCode(resultCode, 17'h00000);
		@(posedge clk);
		dGood <= 1'b1;
		waitFor(1'b0, 1'b0);
		cur = 17'h00000;
		readWord(2'h2);
		#1 cmpFlag(irqN, 1'b1);
		@(posedge clk);
		shut <= 1'b1;
		aGood <= 1'b0;
		repeat (5) @(posedge clk);
		#1 cmpFlag(porActive, 1'b0);
		collapse <= 1'b1;
		waitFor(1'b1, 1'b0);
		collapse <= 1'b0;
		shut <= 1'b0;
		aGood <= 1'b1;
		waitFor(1'b0, 1'b0);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		waitFor(1'b0, 1'b0);
		testDone();
	end
endmodule
`default_nettype wire
